// File: src/intc_pkg.sv
// Register map, field positions and reset values of the interrupt flag and enable bank
package intc_pkg;
   // APB byte offsets
   localparam logic [7:0]  FLAGS2_OFS      = 8'h00;
   localparam logic [7:0]  FLAGS3_OFS      = 8'h04;
   localparam logic [7:0]  FLAGS4_OFS      = 8'h08;
   localparam logic [7:0]  ENABLES0_OFS    = 8'h0c;
   localparam logic [7:0]  SUMMARY_OFS     = 8'h10;
   localparam logic [7:0]  IRQ_MASK_OFS    = 8'h14;
   // Implemented-bit masks and reset values
   localparam logic [15:0] FLAGS2_IMPL     = 16'hdfff;
   localparam logic [15:0] FLAGS3_IMPL     = 16'h39ff;
   localparam logic [15:0] FLAGS4_IMPL     = 16'h00f6;
   localparam logic [15:0] ENABLES0_IMPL   = 16'h7fff;
   localparam logic [15:0] REG_RESET       = 16'h0000;
   localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;
   // Flag bank 2 positions
   localparam int SYNC_PORT2_ERROR_BIT    = 0;
   localparam int SYNC_PORT2_EVENT_BIT    = 1;
   localparam int CAN1_RECEIVE_READY_BIT  = 2;
   localparam int CAN1_EVENT_BIT          = 3;
   // Flag bank 3 positions
   localparam int TIMER7_BIT              = 0;
   localparam int TIMER8_BIT              = 3;
   localparam int TIMER9_BIT              = 4;
   localparam int EXT_PIN3_BIT            = 5;
   localparam int EXT_PIN4_BIT            = 6;
   // Flag bank 4 positions
   localparam int ASYNC_PORT1_ERROR_BIT   = 1;
   localparam int ASYNC_PORT2_ERROR_BIT   = 2;
   localparam int DMA_CH6_DONE_BIT        = 4;
   localparam int DMA_CH7_DONE_BIT        = 5;
   localparam int CAN1_TRANSMIT_REQ_BIT   = 6;
   localparam int CAN2_TRANSMIT_REQ_BIT   = 7;
   // Enable bank 0 positions and flag bank count
   localparam int OUT_COMPARE2_EN_BIT     = 6;
   localparam int TIMER2_EN_BIT           = 7;
   localparam int TIMER3_EN_BIT           = 8;
   localparam int SYNC_PORT1_ERROR_EN_BIT = 9;
   localparam int SYNC_PORT1_EVENT_EN_BIT = 10;
   localparam int ASYNC_PORT1_RX_EN_BIT   = 11;
   localparam int ASYNC_PORT1_TX_EN_BIT   = 12;
   localparam int NUM_FLAG_BANKS          = 3;
endpackage

// File: src/flag_bank_if.sv
// Bus between the main block and one flag bank
`timescale 1ns/10ps
interface flag_bank_if;
   logic [15:0] set_req;
   logic        wr_en;
   logic [15:0] wr_data;
   logic [15:0] value;
   modport ctrl (output set_req, output wr_en, output wr_data, input value);
   modport bank (input set_req, input wr_en, input wr_data, output value);
endinterface

// File: src/flag_bank.sv
// One 16-bit bank of sticky request latches with software write
`timescale 1ns/10ps
module flag_bank
   import intc_pkg::*;
#(
   parameter logic [15:0] IMPL = 16'hffff
) (
   // System
   input  wire logic pclk,
   input  wire logic presetn,
   // Bank access
   flag_bank_if.bank bus
);
   logic [15:0] flags_reg;
   logic [15:0] flags_next;

   always_comb begin
      flags_next = flags_reg;
      if (bus.wr_en) begin
         flags_next = bus.wr_data;
      end
      // Hardware set beats a software clear in the same cycle
      flags_next = (flags_next | bus.set_req) & IMPL; // [RULE_01] [RULE_14]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= REG_RESET; // [RULE_15]
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign bus.value = flags_reg;

   property p_flag_sticky;
      @(posedge pclk) disable iff (!presetn)
         (|(bus.set_req & IMPL)) |=> ((flags_reg & $past(bus.set_req) & IMPL) == ($past(bus.set_req) & IMPL));
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("request not latched"); // [RULE_01]

   property p_flag_hold;
      @(posedge pclk) disable iff (!presetn)
         (!bus.wr_en && bus.set_req == 16'h0000) |=> (flags_reg == $past(flags_reg));
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause"); // [RULE_16]

   property p_flag_unimpl;
      @(posedge pclk) disable iff (!presetn)
         (flags_reg & ~IMPL) == 16'h0000;
   endproperty
   a_flag_unimpl: assert property (p_flag_unimpl) else $error("unimplemented flag bit set"); // [RULE_14]
endmodule

// File: src/interrupt_flag_enable_bank.sv
// APB slave holding flag banks 2-4, enable bank 0 and a summary interrupt
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps

// Operation
// [RULE_01] A flag reads one once its source requested, zero until then.
// [RULE_02] An enable bit at one forwards its source request; zero blocks it.
// [RULE_03] Flag bank 2: sync port 2 error at bit 0, event at bit 1.
// [RULE_04] Flag bank 2: CAN 1 receive ready at bit 2, event at bit 3.
// [RULE_05] Flag bank 3: timer 7 at bit 0, timer 8 bit 3, timer 9 bit 4.
// [RULE_06] Flag bank 3: external pin 4 at bit 6, pin 3 at bit 5.
// [RULE_07] Flag bank 4: CAN 2 transmit request bit 7, CAN 1 bit 6.
// [RULE_08] Flag bank 4: DMA channel 7 done bit 5, channel 6 bit 4.
// [RULE_09] Flag bank 4: async port 2 error bit 2, port 1 bit 1.
// [RULE_10] Enable bank 0: bit 12 async port 1 transmit, bit 11 receive.
// [RULE_11] Enable bank 0: bit 10 sync port 1 event, bit 9 error.
// [RULE_12] Enable bank 0: bit 8 timer 3, bit 7 timer 2.
// [RULE_13] Enable bank 0: bit 6 output compare channel 2.
// [RULE_14] Unimplemented bits read zero and ignore writes.
// [RULE_15] All flag and enable bits clear at reset.
// [RULE_16] Software clears a flag after service; hardware never clears it.
module interrupt_flag_enable_bank
   import intc_pkg::*;
(
   // System
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Flag bank 2 sources
   input  wire logic        sync_port2_error_flag,
   input  wire logic        sync_port2_event_flag,
   input  wire logic        can1_receive_ready_flag,
   input  wire logic        can1_event_flag,
   input  wire logic [15:4] bank2_other_req,
   // Flag bank 3 sources
   input  wire logic        timer7_flag,
   input  wire logic        timer8_flag,
   input  wire logic        timer9_flag,
   input  wire logic        ext_pin3_flag,
   input  wire logic        ext_pin4_flag,
   input  wire logic [2:1]  bank3_i2c2_req,
   input  wire logic [13:7] bank3_other_req,
   // Flag bank 4 sources
   input  wire logic        can2_transmit_request_flag,
   input  wire logic        can1_transmit_request_flag,
   input  wire logic        dma_ch7_done_flag,
   input  wire logic        dma_ch6_done_flag,
   input  wire logic        async_port2_error_flag,
   input  wire logic        async_port1_error_flag,
   // Enable bank 0 outputs
   output logic             async_port1_tx_enable,
   output logic             async_port1_rx_enable,
   output logic             sync_port1_event_enable,
   output logic             sync_port1_error_enable,
   output logic             timer3_enable,
   output logic             timer2_enable,
   output logic             out_compare2_enable,
   output logic      [15:0] enables0_out,
   // Summary interrupt
   output logic             irq
);
   flag_bank_if fb [NUM_FLAG_BANKS] ();

   logic [15:0] bank_set [NUM_FLAG_BANKS];
   logic [15:0] bank_impl [NUM_FLAG_BANKS];
   logic [7:0]  bank_ofs [NUM_FLAG_BANKS];
   logic [15:0] bank_val [NUM_FLAG_BANKS];
   logic [15:0] enables0_reg;
   logic [2:0]  irq_mask_reg;
   logic [2:0]  bank_pending;
   logic        access;
   logic        wr_access;
   logic        addr_ok;
   logic [15:0] wdata16;
   logic [31:0] rdata_next;

   // Source-to-bit placement
   always_comb begin
      bank_set[0] = {bank2_other_req, 4'h0};
      bank_set[0][SYNC_PORT2_ERROR_BIT]   = sync_port2_error_flag;     // [RULE_03]
      bank_set[0][SYNC_PORT2_EVENT_BIT]   = sync_port2_event_flag;     // [RULE_03]
      bank_set[0][CAN1_RECEIVE_READY_BIT] = can1_receive_ready_flag;   // [RULE_04]
      bank_set[0][CAN1_EVENT_BIT]         = can1_event_flag;           // [RULE_04]
      bank_set[1] = {2'h0, bank3_other_req, 7'h00};
      bank_set[1][2:1]                    = bank3_i2c2_req;
      bank_set[1][TIMER7_BIT]             = timer7_flag;               // [RULE_05]
      bank_set[1][TIMER8_BIT]             = timer8_flag;               // [RULE_05]
      bank_set[1][TIMER9_BIT]             = timer9_flag;               // [RULE_05]
      bank_set[1][EXT_PIN3_BIT]           = ext_pin3_flag;             // [RULE_06]
      bank_set[1][EXT_PIN4_BIT]           = ext_pin4_flag;             // [RULE_06]
      bank_set[2] = 16'h0000;
      bank_set[2][CAN2_TRANSMIT_REQ_BIT]  = can2_transmit_request_flag; // [RULE_07]
      bank_set[2][CAN1_TRANSMIT_REQ_BIT]  = can1_transmit_request_flag; // [RULE_07]
      bank_set[2][DMA_CH7_DONE_BIT]       = dma_ch7_done_flag;         // [RULE_08]
      bank_set[2][DMA_CH6_DONE_BIT]       = dma_ch6_done_flag;         // [RULE_08]
      bank_set[2][ASYNC_PORT2_ERROR_BIT]  = async_port2_error_flag;    // [RULE_09]
      bank_set[2][ASYNC_PORT1_ERROR_BIT]  = async_port1_error_flag;    // [RULE_09]
   end

   assign bank_impl[0] = FLAGS2_IMPL;
   assign bank_impl[1] = FLAGS3_IMPL;
   assign bank_impl[2] = FLAGS4_IMPL;
   assign bank_ofs[0]  = FLAGS2_OFS;
   assign bank_ofs[1]  = FLAGS3_OFS;
   assign bank_ofs[2]  = FLAGS4_OFS;

   // One wait state: pready answers the first access-phase cycle
   assign access    = psel && penable && !pready;
   // Writes land only at the edge where the master sees pready high
   assign wr_access = psel && penable && pready && pwrite;
   // Only the low two lanes carry register data
   assign wdata16   = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

   genvar g;
   generate
      for (g = 0; g < NUM_FLAG_BANKS; g++) begin : g_bank
         logic [15:0] lane_keep;
         assign lane_keep = {{8{!pstrb[1]}}, {8{!pstrb[0]}}};
         assign fb[g].set_req = bank_set[g];
         assign fb[g].wr_en   = wr_access && (paddr == bank_ofs[g]);
         // Lanes not strobed keep their old value
         assign fb[g].wr_data = (wdata16 | (fb[g].value & lane_keep)); // [RULE_16]
         assign bank_val[g]   = fb[g].value;
         // Bank-level summary from implemented flags only; enables do not gate it
         assign bank_pending[g] = |(bank_val[g] & bank_impl[g]);
         flag_bank #(
            .IMPL (bank_impl_const(g))
         ) u_bank (
            .pclk    (pclk),
            .presetn (presetn),
            .bus     (fb[g])
         );
      end
   endgenerate

   function automatic logic [15:0] bank_impl_const(input int idx);
      case (idx)
         0:       bank_impl_const = FLAGS2_IMPL;
         1:       bank_impl_const = FLAGS3_IMPL;
         default: bank_impl_const = FLAGS4_IMPL;
      endcase
   endfunction

   // Enable bank 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enables0_reg <= REG_RESET; // [RULE_15]
      end else if (wr_access && paddr == ENABLES0_OFS) begin
         enables0_reg <= ((wdata16 & ENABLES0_IMPL) | (enables0_reg & ~{{8{pstrb[1]}}, {8{pstrb[0]}}})); // [RULE_14]
      end
   end

   // Summary interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= IRQ_MASK_RESET;
      end else if (wr_access && paddr == IRQ_MASK_OFS && pstrb[0]) begin
         irq_mask_reg <= pwdata[2:0];
      end
   end

   // Registered enable outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async_port1_tx_enable   <= 1'b0;
         async_port1_rx_enable   <= 1'b0;
         sync_port1_event_enable <= 1'b0;
         sync_port1_error_enable <= 1'b0;
         timer3_enable           <= 1'b0;
         timer2_enable           <= 1'b0;
         out_compare2_enable     <= 1'b0;
         enables0_out            <= REG_RESET;
      end else begin
         async_port1_tx_enable   <= enables0_reg[ASYNC_PORT1_TX_EN_BIT];   // [RULE_10] [RULE_02]
         async_port1_rx_enable   <= enables0_reg[ASYNC_PORT1_RX_EN_BIT];   // [RULE_10]
         sync_port1_event_enable <= enables0_reg[SYNC_PORT1_EVENT_EN_BIT]; // [RULE_11]
         sync_port1_error_enable <= enables0_reg[SYNC_PORT1_ERROR_EN_BIT]; // [RULE_11]
         timer3_enable           <= enables0_reg[TIMER3_EN_BIT];           // [RULE_12]
         timer2_enable           <= enables0_reg[TIMER2_EN_BIT];           // [RULE_12]
         out_compare2_enable     <= enables0_reg[OUT_COMPARE2_EN_BIT];     // [RULE_13]
         enables0_out            <= enables0_reg;                          // [RULE_02]
      end
   end

   // Level interrupt: any flag in an unmasked bank
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(bank_pending & irq_mask_reg);
      end
   end

   // Read mux and decode
   always_comb begin
      addr_ok    = 1'b1;
      rdata_next = 32'h0000_0000;
      case (paddr)
         FLAGS2_OFS:   rdata_next = {16'h0000, bank_val[0]};
         FLAGS3_OFS:   rdata_next = {16'h0000, bank_val[1]};
         FLAGS4_OFS:   rdata_next = {16'h0000, bank_val[2]};
         ENABLES0_OFS: rdata_next = {16'h0000, enables0_reg};
         SUMMARY_OFS:  rdata_next = {29'h0000_0000, bank_pending};
         IRQ_MASK_OFS: rdata_next = {29'h0000_0000, irq_mask_reg};
         default:      addr_ok    = 1'b0;
      endcase
      if (pwrite && paddr == SUMMARY_OFS) begin
         addr_ok = 1'b0;
      end
   end

   // APB answer, registered one cycle (one wait state) after the access phase opens
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access;
         pslverr <= access && !addr_ok;
         if (access && !pwrite) begin
            prdata <= rdata_next;
         end
      end
   end

   property p_enable_follows;
      @(posedge pclk) disable iff (!presetn)
         (wr_access && paddr == ENABLES0_OFS && pstrb[1] && pstrb[0])
            |=> ##1 (timer3_enable == $past(pwdata[TIMER3_EN_BIT], 2)
                     && out_compare2_enable == $past(pwdata[OUT_COMPARE2_EN_BIT], 2));
   endproperty
   a_enable_follows: assert property (p_enable_follows) else $error("enable output not updated"); // [RULE_02]

   property p_enable_tx_rx;
      @(posedge pclk) disable iff (!presetn)
         ##1 (async_port1_tx_enable == $past(enables0_reg[12])
              && async_port1_rx_enable == $past(enables0_reg[11]));
   endproperty
   a_enable_tx_rx: assert property (p_enable_tx_rx) else $error("async port 1 enable misplaced"); // [RULE_10]

   property p_enable_sync;
      @(posedge pclk) disable iff (!presetn)
         ##1 (sync_port1_event_enable == $past(enables0_reg[10])
              && sync_port1_error_enable == $past(enables0_reg[9]));
   endproperty
   a_enable_sync: assert property (p_enable_sync) else $error("sync port 1 enable misplaced"); // [RULE_11]

   property p_enable_timer;
      @(posedge pclk) disable iff (!presetn)
         ##1 (timer3_enable == $past(enables0_reg[8]) && timer2_enable == $past(enables0_reg[7]));
   endproperty
   a_enable_timer: assert property (p_enable_timer) else $error("timer enable misplaced"); // [RULE_12]

   property p_enable_unimpl;
      @(posedge pclk) disable iff (!presetn)
         enables0_reg[15] == 1'b0;
   endproperty
   a_enable_unimpl: assert property (p_enable_unimpl) else $error("enable bit 15 set"); // [RULE_14]

   sequence s_write_setup;
      psel && !penable;
   endsequence
   sequence s_write_done;
      ##1 (psel && penable) ##1 pready;
   endsequence
   property p_apb_answer;
      @(posedge pclk) disable iff (!presetn)
         s_write_setup |-> s_write_done or (##1 !penable);
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer late"); // [RULE_16]

   property p_timer9_latch;
      @(posedge pclk) disable iff (!presetn)
         timer9_flag |=> bank_val[1][4];
   endproperty
   a_timer9_latch: assert property (p_timer9_latch) else $error("timer 9 flag not at bit 4"); // [RULE_05]

   property p_can2_tx_latch;
      @(posedge pclk) disable iff (!presetn)
         (can2_transmit_request_flag |=> bank_val[2][7]) and (can1_transmit_request_flag |=> bank_val[2][6]);
   endproperty
   a_can2_tx_latch: assert property (p_can2_tx_latch) else $error("can 2 transmit flag not at bit 7"); // [RULE_07]

   property p_irq_level;
      @(posedge pclk) disable iff (!presetn)
         |(bank_pending & irq_mask_reg) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not raised"); // [RULE_01]

   property p_sync_port2_latch;
      @(posedge pclk) disable iff (!presetn)
         (sync_port2_error_flag |=> bank_val[0][0]) and (sync_port2_event_flag |=> bank_val[0][1]);
   endproperty
   a_sync_port2_latch: assert property (p_sync_port2_latch) else $error("sync port 2 flag misplaced"); // [RULE_03]

   property p_can1_latch;
      @(posedge pclk) disable iff (!presetn)
         (can1_receive_ready_flag |=> bank_val[0][2]) and (can1_event_flag |=> bank_val[0][3]);
   endproperty
   a_can1_latch: assert property (p_can1_latch) else $error("can 1 flag misplaced"); // [RULE_04]

   property p_timer7_8_latch;
      @(posedge pclk) disable iff (!presetn)
         (timer7_flag |=> bank_val[1][0]) and (timer8_flag |=> bank_val[1][3]);
   endproperty
   a_timer7_8_latch: assert property (p_timer7_8_latch) else $error("timer flag misplaced"); // [RULE_05]

   property p_ext_pin_latch;
      @(posedge pclk) disable iff (!presetn)
         (ext_pin4_flag |=> bank_val[1][6]) and (ext_pin3_flag |=> bank_val[1][5]);
   endproperty
   a_ext_pin_latch: assert property (p_ext_pin_latch) else $error("pin flag misplaced"); // [RULE_06]

   property p_dma_latch;
      @(posedge pclk) disable iff (!presetn)
         (dma_ch7_done_flag |=> bank_val[2][5]) and (dma_ch6_done_flag |=> bank_val[2][4]);
   endproperty
   a_dma_latch: assert property (p_dma_latch) else $error("dma flag misplaced"); // [RULE_08]

   property p_async_error_latch;
      @(posedge pclk) disable iff (!presetn)
         (async_port2_error_flag |=> bank_val[2][2]) and (async_port1_error_flag |=> bank_val[2][1]);
   endproperty
   a_async_error_latch: assert property (p_async_error_latch) else $error("async error flag misplaced"); // [RULE_09]

   property p_enable_compare;
      @(posedge pclk) disable iff (!presetn)
         ##1 (out_compare2_enable == $past(enables0_reg[6]));
   endproperty
   a_enable_compare: assert property (p_enable_compare) else $error("compare enable misplaced"); // [RULE_13]

   property p_reset_clear;
      @(posedge pclk)
         $rose(presetn) |-> (enables0_reg == REG_RESET && bank_pending == 3'h0 && irq == 1'b0 && !pready);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset"); // [RULE_15]
endmodule

// File: tb/intc_source_model.sv
// Behavioural model of the peripheral request sources feeding the flag banks
`timescale 1ns/10ps
module intc_source_model (
   // System
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Pulse commands: bank 2 in 15:0, bank 3 in 31:16, bank 4 in 47:32
   input  wire logic [47:0] pulse_cmd,
   // Request lines
   output logic      [15:0] b2_req,
   output logic      [15:0] b3_req,
   output logic      [15:0] b4_req
);
   logic [47:0] req_reg;

   // Peripherals strobe a request for one cycle only, so the flag must latch it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_reg <= 48'h0;
      end else begin
         req_reg <= pulse_cmd;
      end
   end

   assign b2_req = req_reg[15:0];
   assign b3_req = req_reg[31:16];
   assign b4_req = req_reg[47:32];
endmodule

// File: tb/interrupt_flag_enable_bank_bench.sv
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/10ps
module interrupt_flag_enable_bank_bench
   import intc_pkg::*;
;
   typedef struct {logic [31:0] data; logic chk; logic err;} note_type;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [47:0] pulse_cmd;
   logic [15:0] b2_req, b3_req, b4_req, enables0_out, exp16;
   logic        tx_en, rx_en, ev_en, er_en, t3_en, t2_en, oc2_en;
   note_type    notes[$];
   note_type    cur;
   int          err_count, num_checks, cycles;

   intc_source_model intc_source_model_inst (.pclk(pclk), .presetn(presetn), .pulse_cmd(pulse_cmd),
      .b2_req(b2_req), .b3_req(b3_req), .b4_req(b4_req));

   interrupt_flag_enable_bank interrupt_flag_enable_bank_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync_port2_error_flag(b2_req[0]), .sync_port2_event_flag(b2_req[1]),
      .can1_receive_ready_flag(b2_req[2]), .can1_event_flag(b2_req[3]), .bank2_other_req(b2_req[15:4]),
      .timer7_flag(b3_req[0]), .timer8_flag(b3_req[3]), .timer9_flag(b3_req[4]), .ext_pin3_flag(b3_req[5]),
      .ext_pin4_flag(b3_req[6]), .bank3_i2c2_req(b3_req[2:1]), .bank3_other_req(b3_req[13:7]),
      .can2_transmit_request_flag(b4_req[7]), .can1_transmit_request_flag(b4_req[6]),
      .dma_ch7_done_flag(b4_req[5]), .dma_ch6_done_flag(b4_req[4]),
      .async_port2_error_flag(b4_req[2]), .async_port1_error_flag(b4_req[1]),
      .async_port1_tx_enable(tx_en), .async_port1_rx_enable(rx_en), .sync_port1_event_enable(ev_en),
      .sync_port1_error_enable(er_en), .timer3_enable(t3_en), .timer2_enable(t2_en),
      .out_compare2_enable(oc2_en), .enables0_out(enables0_out), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   function automatic logic [7:0] ofs(input int b);
      return (b == 0) ? FLAGS2_OFS : (b == 1) ? FLAGS3_OFS : (b == 2) ? FLAGS4_OFS : ENABLES0_OFS;
   endfunction

   function automatic logic [15:0] impl(input int b);
      return (b == 0) ? FLAGS2_IMPL : (b == 1) ? FLAGS3_IMPL : (b == 2) ? FLAGS4_IMPL : ENABLES0_IMPL;
   endfunction

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Request held until pready is sampled high; the result is noted for the monitor
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                      input logic chk, input logic err);
      notes.push_back('{exp, chk, err});
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, exp, 1'b1, 1'b0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0, 1'b0);
   endtask

   task automatic pulse(input int b, input int i);
      @(posedge pclk);
      pulse_cmd <= 48'h1 << (16 * b + i);
      @(posedge pclk);
      pulse_cmd <= 48'h0;
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Read data is taken only at the edge where pready is high
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            check("unexpected pready", 32'h0, 32'h1);
         end else begin
            cur = notes.pop_front();
            check("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
            if (cur.chk === 1'b1) begin
               check("prdata", cur.data, prdata);
            end
         end
      end
   end

   // Whole run needs about 1200 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic reset_dut();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         rd(ofs(b), 32'h0);
      end
      rd(IRQ_MASK_OFS, 32'h0);
      check("enables0_out", 32'h0, {16'h0, enables0_out});
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h3;
      pulse_cmd = 48'h0;
      err_count = 0;
      num_checks = 0;
      cycles = 0;
      void'($urandom(54570));
      reset_dut();
      for (int b = 0; b < 3; b++) begin
         for (int i = 0; i < 16; i++) begin
            pulse(b, i);
            rd(ofs(b), {16'h0, impl(b) & (16'h1 << i)});
            wr(ofs(b), 32'h0);
            rd(ofs(b), 32'h0);
         end
      end
      repeat (6) begin
         for (int b = 0; b < 4; b++) begin
            pwdata <= $urandom;
            @(posedge pclk);
            exp16 = pwdata[15:0];
            wr(ofs(b), pwdata);
            rd(ofs(b), {16'h0, exp16 & impl(b)});
            wr(ofs(b), 32'h0);
         end
      end
      for (int i = 0; i < 16; i++) begin
         wr(ENABLES0_OFS, 32'h1 << i);
         repeat (2) @(posedge pclk);
         exp16 = ENABLES0_IMPL & (16'h1 << i);
         check("enables0_out", {16'h0, exp16}, {16'h0, enables0_out});
         check("named enables", {25'h0, exp16[12:6]}, {25'h0, tx_en, rx_en, ev_en, er_en, t3_en, t2_en, oc2_en});
      end
      // Only strobed lanes of the enable register change
      wr(ENABLES0_OFS, 32'hffff_ffff);
      pstrb <= 4'h1;
      wr(ENABLES0_OFS, 32'h0);
      pstrb <= 4'h3;
      rd(ENABLES0_OFS, {16'h0, ENABLES0_IMPL & 16'hff00});
      wr(IRQ_MASK_OFS, 32'h2);
      pulse(1, TIMER8_BIT);
      rd(SUMMARY_OFS, 32'h2);
      check("irq", 32'h1, {31'h0, irq});
      wr(IRQ_MASK_OFS, 32'h5);
      repeat (2) @(posedge pclk);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(IRQ_MASK_OFS, 32'h2);
      repeat (2) @(posedge pclk);
      check("irq unmasked", 32'h1, {31'h0, irq});
      wr(FLAGS3_OFS, 32'h0);
      repeat (2) @(posedge pclk);
      check("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, SUMMARY_OFS, 32'h7, 32'h0, 1'b0, 1'b1);
      apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b0, 1'b1);
      // Second reset in mid-run with flags and enables set
      pulse(2, DMA_CH7_DONE_BIT);
      wr(ENABLES0_OFS, 32'h1000);
      rd(FLAGS4_OFS, 32'h0000_0020);
      check("tx enable", 32'h1, {31'h0, tx_en});
      repeat (3) @(posedge pclk);
      reset_dut();
      tally_and_finish();
   end
endmodule
